/* include/eeprom_i2c_pkg.sv */
// Constants and types shared by the serial slave and its write buffer
package eeprom_i2c_pkg;

  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int BYTE_COUNT  = 2048;
  localparam int WORD_COUNT  = 512;
  localparam int WORD_WIDTH  = 32;
  localparam int BYTE_AW     = 11;
  localparam int WORD_AW     = 9;
  localparam int FIFO_DEPTH  = 32;

  // ****************************************************************
  // Select byte layout
  // ****************************************************************
  localparam int SEL_TYPE_MSB  = 7;
  localparam int SEL_TYPE_LSB  = 4;
  localparam int SEL_UPPER_BIT = 3;
  localparam int SEL_FIX_MSB   = 2;
  localparam int SEL_FIX_LSB   = 1;
  localparam int SEL_RW_BIT    = 0;
  // Type code value is arbitrary
  localparam logic [3:0] TYPE_ID      = 4'h6;
  localparam logic [1:0] FIXED_ONES   = 2'h3;
  localparam logic       UPPER_SELECT = 1'h0;
  localparam int         HI_ADDR_BITS = 3;

  // ****************************************************************
  // Serial framing and timing
  // ****************************************************************
  localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
  localparam logic        MODE_WIP        = 1'h0;
  localparam logic        MODE_BUSY       = 1'h1;
  localparam int          RF_WRITE_CYCLES = 1024;
  localparam int          SYNC_WIDTH      = 5;

  // ****************************************************************
  // Carried types
  // ****************************************************************
  typedef struct packed {
    logic [BYTE_AW-1:0] addr;
    logic [7:0]         data;
  } wr_item_type;

  typedef struct packed {
    logic scl;
    logic sda;
    logic vcc_ok;
    logic harvest_en;
    logic field_ok;
  } pin_group_type;

endpackage

/* rtl/write_fifo.sv */
// Synchronous FIFO buffering serial writes before they reach the array
`timescale 1ns/1ps
module write_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  // Filling side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    wr_ptr_next;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW-1:0]    rd_ptr_next;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = store[rd_ptr_reg];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    wr_ptr_next = push ? bump(wr_ptr_reg) : wr_ptr_reg;
    rd_ptr_next = pop ? bump(rd_ptr_reg) : rd_ptr_reg;
    count_next  = count_reg;
    if (push & ~pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop & ~push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      store[wr_ptr_reg] <= in_data_i;
    end
  end
endmodule

/* rtl/dual_port_eeprom_i2c_slave.sv */
// Serial-bus slave, shared array and contactless status pin of the EEPROM
`timescale 1ns/1ps
module dual_port_eeprom_i2c_slave #(
  parameter int RF_WRITE_CYCLES = eeprom_i2c_pkg::RF_WRITE_CYCLES,
  parameter int FIFO_DEPTH      = eeprom_i2c_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  // Serial bus pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  // Supply and harvesting pins
  input  wire logic        vcc_ok_i,
  input  wire logic        harvest_en_i,
  input  wire logic        field_ok_i,
  output logic             harvest_oe_o,
  // Status pin and its configuration
  input  wire logic        status_mode_i,
  output logic             contactless_activity_out_o,
  output logic             contactless_activity_out_oe_o,
  // Contactless word port
  input  wire logic        rf_cmd_active_i,
  input  wire logic        rf_wr_i,
  input  wire logic [8:0]  rf_addr_i,
  input  wire logic [31:0] rf_wdata_i,
  output logic [31:0]      rf_rdata_o,
  output logic             rf_wr_busy_o
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  eeprom_i2c_pkg::pin_group_type pin_meta_reg;
  eeprom_i2c_pkg::pin_group_type pin_sync_reg;
  eeprom_i2c_pkg::pin_group_type pin_raw;
  logic                          scl_prev_reg;
  logic                          sda_prev_reg;

  assign pin_raw = '{scl: scl_i, sda: sda_i, vcc_ok: vcc_ok_i,
                     harvest_en: harvest_en_i, field_ok: field_ok_i};

  // Meta stage feeds only the second stage; edges come from stage two
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pin_meta_reg <= '{scl: 1'h1, sda: 1'h1, default: 1'h0};
      pin_sync_reg <= '{scl: 1'h1, sda: 1'h1, default: 1'h0};
      scl_prev_reg <= 1'h1;
      sda_prev_reg <= 1'h1;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
      scl_prev_reg <= pin_sync_reg.scl;
      sda_prev_reg <= pin_sync_reg.sda;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  // Bit timing is taken from serial clock edges, Start and Stop from data edges while the clock is high
  assign scl_rise   = pin_sync_reg.scl & ~scl_prev_reg;
  assign scl_fall   = ~pin_sync_reg.scl & scl_prev_reg;
  assign start_seen = pin_sync_reg.scl & scl_prev_reg &
                      sda_prev_reg & ~pin_sync_reg.sda;
  assign stop_seen  = pin_sync_reg.scl & scl_prev_reg &
                      ~sda_prev_reg & pin_sync_reg.sda;

  // ****************************************************************
  // Shared array
  // ****************************************************************
  logic [31:0] mem_array [0:eeprom_i2c_pkg::WORD_COUNT-1];

  // Byte view of the word array, lane 0 in the low bits
  function automatic logic [7:0] byte_at(
    input logic [eeprom_i2c_pkg::BYTE_AW-1:0] a
  );
    logic [31:0] w;
    w       = mem_array[a[eeprom_i2c_pkg::BYTE_AW-1:2]];
    byte_at = w[a[1:0]*8 +: 8];
  endfunction

  // ****************************************************************
  // Serial slave state machine
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_SEL, ST_ADDR_HI, ST_ADDR_LO, ST_WRITE, ST_READ, ST_IGNORE
  } bus_state_type;

  bus_state_type                     state_reg;
  bus_state_type                     state_next;
  logic [3:0]                        bit_cnt_reg;
  logic [3:0]                        bit_cnt_next;
  logic                              ack_phase_reg;
  logic                              ack_phase_next;
  logic                              ack_give_reg;
  logic                              ack_give_next;
  logic [7:0]                        rx_reg;
  logic [7:0]                        rx_next;
  logic [7:0]                        tx_reg;
  logic [7:0]                        tx_next;
  logic [eeprom_i2c_pkg::BYTE_AW-1:0] addr_reg;
  logic [eeprom_i2c_pkg::BYTE_AW-1:0] addr_next;
  logic                              sda_oe_reg;
  logic                              sda_oe_next;
  logic                              read_dir_reg;
  logic                              read_dir_next;
  eeprom_i2c_pkg::wr_item_type       push_item;
  logic                              push_valid;
  logic                              push_ready;

  logic       sel_match;
  logic [7:0] rx_full;

  assign rx_full   = rx_reg;
  // Type, fixed ones and upper select all checked, MSB first
  assign sel_match =
    (rx_full[eeprom_i2c_pkg::SEL_TYPE_MSB:eeprom_i2c_pkg::SEL_TYPE_LSB]
      == eeprom_i2c_pkg::TYPE_ID) &&
    (rx_full[eeprom_i2c_pkg::SEL_FIX_MSB:eeprom_i2c_pkg::SEL_FIX_LSB]
      == eeprom_i2c_pkg::FIXED_ONES) &&
    (rx_full[eeprom_i2c_pkg::SEL_UPPER_BIT] == eeprom_i2c_pkg::UPPER_SELECT);

  always_comb begin
    state_next     = state_reg;
    bit_cnt_next   = bit_cnt_reg;
    ack_phase_next = ack_phase_reg;
    ack_give_next  = ack_give_reg;
    rx_next        = rx_reg;
    tx_next        = tx_reg;
    addr_next      = addr_reg;
    sda_oe_next    = sda_oe_reg;
    read_dir_next  = read_dir_reg;
    push_valid     = 1'h0;
    push_item      = '{addr: addr_reg, data: rx_reg};
    if (stop_seen) begin
      // Stop releases the line and returns to standby
      state_next     = ST_IDLE;
      sda_oe_next    = 1'h0;
      ack_phase_next = 1'h0;
    end else if (start_seen) begin
      // A Start, repeated or not, always reopens select framing
      state_next     = ST_SEL;
      bit_cnt_next   = '0;
      ack_phase_next = 1'h0;
      sda_oe_next    = 1'h0;
    end else begin
      case (state_reg)
        ST_SEL, ST_ADDR_HI, ST_ADDR_LO, ST_WRITE: begin
          if (scl_rise && bit_cnt_reg != eeprom_i2c_pkg::BITS_PER_BYTE) begin
            rx_next      = {rx_reg[6:0], pin_sync_reg.sda};
            bit_cnt_next = bit_cnt_reg + 1'b1;
          end else if (scl_fall && bit_cnt_reg ==
                       eeprom_i2c_pkg::BITS_PER_BYTE && !ack_phase_reg) begin
            // Byte complete: decide the ninth slot now
            ack_phase_next = 1'h1;
            ack_give_next  = 1'h1;
            case (state_reg)
              ST_SEL: begin
                ack_give_next = sel_match;
                read_dir_next = rx_reg[eeprom_i2c_pkg::SEL_RW_BIT];
              end
              ST_ADDR_HI: begin
                addr_next[eeprom_i2c_pkg::BYTE_AW-1:8] =
                  rx_reg[eeprom_i2c_pkg::HI_ADDR_BITS-1:0];
              end
              ST_ADDR_LO: begin
                addr_next[7:0] = rx_reg;
              end
              default: begin
                // Full buffer refuses the byte with a not-acknowledge
                push_valid    = 1'h1;
                ack_give_next = push_ready;
                if (push_ready) begin
                  addr_next = addr_reg + 1'b1;
                end
              end
            endcase
            sda_oe_next = ack_give_next;
          end else if (scl_fall && ack_phase_reg) begin
            ack_phase_next = 1'h0;
            bit_cnt_next   = '0;
            sda_oe_next    = 1'h0;
            if (!ack_give_reg) begin
              // Foreign or refused byte: silent until next Start
              state_next = ST_IGNORE;
            end else begin
              case (state_reg)
                ST_SEL: begin
                  if (read_dir_reg) begin
                    state_next  = ST_READ;
                    tx_next     = byte_at(addr_reg);
                    sda_oe_next = ~tx_next[7];
                  end else begin
                    state_next = ST_ADDR_HI;
                  end
                end
                ST_ADDR_HI: state_next = ST_ADDR_LO;
                default:    state_next = ST_WRITE;
              endcase
            end
          end
        end
        ST_READ: begin
          if (scl_rise) begin
            if (bit_cnt_reg == eeprom_i2c_pkg::BITS_PER_BYTE) begin
              // Master acknowledge keeps reading, a high ends it
              if (pin_sync_reg.sda) begin
                state_next = ST_IGNORE;
              end else begin
                addr_next    = addr_reg + 1'b1;
                tx_next      = byte_at(addr_next);
                bit_cnt_next = '0;
              end
            end else begin
              tx_next      = {tx_reg[6:0], 1'h0};
              bit_cnt_next = bit_cnt_reg + 1'b1;
            end
          end else if (scl_fall) begin
            // Released in the ninth slot so the master can answer
            sda_oe_next = (bit_cnt_reg != eeprom_i2c_pkg::BITS_PER_BYTE) &
                          ~tx_reg[7];
          end
        end
        ST_IDLE, ST_IGNORE: begin
          sda_oe_next = 1'h0;
        end
        default: begin
          state_next  = ST_IDLE;
          sda_oe_next = 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_reg     <= ST_IDLE;
      bit_cnt_reg   <= '0;
      ack_phase_reg <= 1'h0;
      ack_give_reg  <= 1'h0;
      rx_reg        <= '0;
      tx_reg        <= '0;
      addr_reg      <= '0;
      sda_oe_reg    <= 1'h0;
      read_dir_reg  <= 1'h0;
    end else begin
      state_reg     <= state_next;
      bit_cnt_reg   <= bit_cnt_next;
      ack_phase_reg <= ack_phase_next;
      ack_give_reg  <= ack_give_next;
      rx_reg        <= rx_next;
      tx_reg        <= tx_next;
      addr_reg      <= addr_next;
      sda_oe_reg    <= sda_oe_next;
      read_dir_reg  <= read_dir_next;
    end
  end

  // ****************************************************************
  // Write buffer and array ports
  // ****************************************************************
  eeprom_i2c_pkg::wr_item_type drain_item;
  logic                        drain_valid;
  logic                        drain_ready;
  logic                        rf_we;
  logic                        wip_reg;
  logic                        wip_next;
  logic [$clog2(RF_WRITE_CYCLES+1)-1:0] wip_cnt_reg;
  logic [$clog2(RF_WRITE_CYCLES+1)-1:0] wip_cnt_next;

  write_fifo #(
    .WIDTH ($bits(eeprom_i2c_pkg::wr_item_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_write_fifo (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (push_item),
    .out_valid_o (drain_valid),
    .out_ready_i (drain_ready),
    .out_data_o  (drain_item)
  );

  // Serial reads do not look into the buffer; pending bytes may be stale
  assign rf_we       = rf_wr_i & ~wip_reg;
  assign drain_ready = ~wip_reg & ~rf_wr_i;

  always_ff @(posedge clk_sys_i) begin
    if (rf_we) begin
      mem_array[rf_addr_i] <= rf_wdata_i;
    end else if (drain_valid & drain_ready) begin
      mem_array[drain_item.addr[eeprom_i2c_pkg::BYTE_AW-1:2]]
        [drain_item.addr[1:0]*8 +: 8] <= drain_item.data;
    end
  end

  // ****************************************************************
  // Contactless write cycle and status pin
  // ****************************************************************
  logic status_pull;
  logic act_oe_reg;
  logic act_oe_next;
  logic harvest_reg;
  logic harvest_next;
  logic [31:0] rf_rdata_reg;

  always_comb begin
    wip_next     = wip_reg;
    wip_cnt_next = wip_cnt_reg;
    if (rf_we) begin
      wip_next     = 1'h1;
      wip_cnt_next = ($clog2(RF_WRITE_CYCLES+1))'(RF_WRITE_CYCLES - 1);
    end else if (wip_reg) begin
      if (wip_cnt_reg == '0) begin
        wip_next = 1'h0;
      end else begin
        wip_cnt_next = wip_cnt_reg - 1'b1;
      end
    end
    if (status_mode_i == eeprom_i2c_pkg::MODE_WIP) begin
      status_pull = wip_reg;
    end else begin
      status_pull = rf_cmd_active_i | wip_reg;
    end
    // Pulled only on a good wired supply, else released
    act_oe_next  = status_pull & pin_sync_reg.vcc_ok;
    harvest_next = pin_sync_reg.harvest_en & pin_sync_reg.field_ok;
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wip_reg      <= 1'h0;
      wip_cnt_reg  <= '0;
      act_oe_reg   <= 1'h0;
      harvest_reg  <= 1'h0;
      rf_rdata_reg <= '0;
    end else begin
      wip_reg      <= wip_next;
      wip_cnt_reg  <= wip_cnt_next;
      act_oe_reg   <= act_oe_next;
      harvest_reg  <= harvest_next;
      rf_rdata_reg <= mem_array[rf_addr_i];
    end
  end

  // Both open-drain data values are a constant low from a flip-flop
  logic drive_low_reg;

  always_ff @(posedge clk_sys_i) begin
    drive_low_reg <= 1'h0;
  end

  assign sda_o                         = drive_low_reg;
  assign sda_oe_o                      = sda_oe_reg;
  assign contactless_activity_out_o    = drive_low_reg;
  assign contactless_activity_out_oe_o = act_oe_reg;
  assign harvest_oe_o                  = harvest_reg;
  assign rf_rdata_o                    = rf_rdata_reg;
  assign rf_wr_busy_o                  = wip_reg;
endmodule

/* sim/eeprom_i2c_sva.sv */
// Checker for the status, harvest and write-cycle pins of the slave
`timescale 1ns/1ps
module eeprom_i2c_sva #(
  parameter int RF_WRITE_CYCLES = 8,
  parameter int FIFO_DEPTH      = 32
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Pins
  input wire logic sda_o,
  input wire logic vcc_ok_i,
  input wire logic harvest_en_i,
  input wire logic field_ok_i,
  input wire logic harvest_oe_o,
  input wire logic status_mode_i,
  input wire logic contactless_activity_out_o,
  input wire logic contactless_activity_out_oe_o,
  // Contactless port
  input wire logic rf_cmd_active_i,
  input wire logic rf_wr_i,
  input wire logic rf_wr_busy_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  // Length of the running write cycle
  logic [15:0] busy_cnt_reg;
  logic [15:0] busy_cnt_next;
  always_comb busy_cnt_next = rf_wr_busy_o ? busy_cnt_reg + 16'h1 : 16'h0;
  always_ff @(posedge clk_sys_i) begin
    busy_cnt_reg <= sys_rst_i ? 16'h0 : busy_cnt_next;
  end

  // Supply must settle through the synchronisers first
  sequence s_vcc_up;
    vcc_ok_i [*4];
  endsequence
  sequence s_vcc_down;
    !vcc_ok_i [*4];
  endsequence

  a_pins_low_only: assert property (
    !sda_o && !contactless_activity_out_o)
    else $error("open drain pin drives high");
  a_busy_start: assert property (
    rf_wr_i && !rf_wr_busy_o |=> $rose(rf_wr_busy_o))
    else $error("write cycle did not start");
  a_busy_len: assert property (
    $fell(rf_wr_busy_o) |-> busy_cnt_reg == RF_WRITE_CYCLES)
    else $error("write cycle length wrong");
  a_busy_bound: assert property (
    rf_wr_busy_o |-> busy_cnt_reg < RF_WRITE_CYCLES)
    else $error("write cycle overruns");
  a_wip_pull: assert property (
    s_vcc_up ##0 rf_wr_busy_o |=> contactless_activity_out_oe_o)
    else $error("status not low during write");
  a_cmd_pull: assert property (
    s_vcc_up ##0 (rf_cmd_active_i &&
      status_mode_i == eeprom_i2c_pkg::MODE_BUSY)
    |=> contactless_activity_out_oe_o)
    else $error("status not low during command");
  a_idle_release: assert property (
    !rf_wr_busy_o && (status_mode_i == eeprom_i2c_pkg::MODE_WIP ||
      !rf_cmd_active_i) |=> !contactless_activity_out_oe_o)
    else $error("status pulled while idle");
  a_vcc_gate: assert property (
    s_vcc_down |=> !contactless_activity_out_oe_o)
    else $error("status driven without supply");
  a_harvest_on: assert property (
    (harvest_en_i && field_ok_i) [*4] |=> harvest_oe_o)
    else $error("harvest output not active");
  a_harvest_off: assert property (
    (!harvest_en_i || !field_ok_i) [*4] |=> !harvest_oe_o)
    else $error("harvest output not floated");
endmodule

bind dual_port_eeprom_i2c_slave eeprom_i2c_sva #(
  .RF_WRITE_CYCLES(RF_WRITE_CYCLES),
  .FIFO_DEPTH(FIFO_DEPTH)
) u_sva (.clk_sys_i, .sys_rst_i, .sda_o, .vcc_ok_i, .harvest_en_i,
  .field_ok_i, .harvest_oe_o, .status_mode_i, .contactless_activity_out_o,
  .contactless_activity_out_oe_o, .rf_cmd_active_i, .rf_wr_i, .rf_wr_busy_o);

/* sim/i2c_master_model.sv */
// Serial bus master model; clock idles high between frames
`timescale 1ns/1ps
module i2c_master_model (
  // Bus lines
  output logic      scl_o,
  output logic      sda_o,
  input  wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Data moves mid-low and is sampled mid-high, clear of sync lag
  task automatic slot(input logic v, output logic s);
    #12 sda_o = v;
    #12 scl_o = 1'b1;
    #12 s = sda_i;
    #12 scl_o = 1'b0;
  endtask
  task automatic start();
    #12 sda_o = 1'b1;
    #12 scl_o = 1'b1;
    #12 sda_o = 1'b0;
    #12 scl_o = 1'b0;
  endtask
  task automatic stop();
    #12 sda_o = 1'b0;
    #12 scl_o = 1'b1;
    #12 sda_o = 1'b1;
    #12;
  endtask
  // Released bits (1) let the slave drive during reads
  task automatic xfer(input logic [7:0] b, input logic a,
                      output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) slot(b[i], r[i]);
    slot(a, k);
  endtask
endmodule

/* sim/tb.sv */
// Self-checking bench for the dual-port EEPROM serial slave
`timescale 1ns/1ps
module tb;
  localparam int RFW = 8;
  localparam logic [7:0] SEL_W = {eeprom_i2c_pkg::TYPE_ID,
    eeprom_i2c_pkg::UPPER_SELECT, eeprom_i2c_pkg::FIXED_ONES, 1'b0};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        scl, m_sda, sda_o, sda_oe, sda_w, h_oe, act, act_oe, busy;
  logic        vcc_ok = 1'b1, h_en = 1'b0, f_ok = 1'b0, cmd = 1'b0;
  logic        mode = eeprom_i2c_pkg::MODE_WIP, rf_wr = 1'b0;
  logic [8:0]  rf_addr = 9'h000;
  logic [31:0] rf_wdata = 32'h0, rf_rdata, w;
  logic [7:0]  mem [2048];
  logic [7:0]  msk [4] = '{8'h80, 8'h10, 8'h08, 8'h04};
  integer      seed = 32'hF2A5;
  int          n_mismatch = 0, total_checks = 0, cycles = 0;

  always #2.5 clk = ~clk;
  // Pull-up on the data line
  assign sda_w = m_sda & ~(sda_oe & ~sda_o);

  i2c_master_model u_m (.scl_o(scl), .sda_o(m_sda), .sda_i(sda_w));
  dual_port_eeprom_i2c_slave #(.RF_WRITE_CYCLES(RFW), .FIFO_DEPTH(32)) u_dut (
    .clk_sys_i(clk), .sys_rst_i(rst), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .vcc_ok_i(vcc_ok),
    .harvest_en_i(h_en), .field_ok_i(f_ok), .harvest_oe_o(h_oe),
    .status_mode_i(mode), .contactless_activity_out_o(act),
    .contactless_activity_out_oe_o(act_oe), .rf_cmd_active_i(cmd),
    .rf_wr_i(rf_wr), .rf_addr_i(rf_addr), .rf_wdata_i(rf_wdata),
    .rf_rdata_o(rf_rdata), .rf_wr_busy_o(busy));

  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Acknowledge shows as a low data line, silence as the pull-up level
  function automatic logic [31:0] ack_line(input logic ack);
    ack_line = ack ? 32'h0 : 32'h1;
  endfunction
  task automatic sbyte(input logic [7:0] b, input logic ack);
    logic [7:0] r;
    logic       k;
    u_m.xfer(b, 1'b1, r, k);
    chk(32'(k), ack_line(ack));
  endtask
  task automatic hdr(input logic [10:0] a);
    u_m.start();
    sbyte(SEL_W, 1'b1);
    sbyte({5'h00, a[10:8]}, 1'b1);
    sbyte(a[7:0], 1'b1);
  endtask
  task automatic wr_seq(input logic [10:0] a, input int n, input int n_ack);
    logic [7:0] b;
    hdr(a);
    for (int i = 0; i < n; i++) begin
      b = 8'($random(seed));
      sbyte(b, i < n_ack);
      if (i < n_ack) mem[a + 11'(i)] = b;
    end
    u_m.stop();
    // Back on the clock grid before same-clock inputs move
    step(1);
  endtask
  task automatic rd_seq(input logic [10:0] a, input int n);
    logic [7:0] r;
    logic       k;
    hdr(a);
    u_m.start();
    sbyte(SEL_W | 8'h01, 1'b1);
    for (int i = 0; i < n; i++) begin
      u_m.xfer(8'hFF, i == n - 1, r, k);
      chk(32'(r), 32'(mem[a + 11'(i)]));
    end
    u_m.stop();
    step(1);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 100 && busy !== 1'b0; i++) step(1);
    chk(32'(busy), 32'h0);
  endtask
  task automatic rf_put(input logic [8:0] wa, input logic [31:0] wd);
    rf_addr = wa;
    rf_wdata = wd;
    for (int j = 0; j < 4; j++) mem[{wa, 2'(j)}] = wd[8*j +: 8];
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    step(8);
    rst = 1'b0;
    // Foreign select bytes are left unanswered, and so is what follows
    for (int i = 0; i < 4; i++) begin
      u_m.start();
      sbyte(SEL_W ^ msk[i] ^ 8'($random(seed) & 1), 1'b0);
      sbyte(8'h00, 1'b0);
      u_m.stop();
    end
    // Burst across the top of the array wraps to byte zero
    wr_seq(11'h7FE, 4, 4);
    rd_seq(11'h7FE, 4);
    rf_addr = 9'h1FF;
    step(2);
    chk(rf_rdata[31:16], {16'h0, mem[2047], mem[2046]});
    // Contactless write, a second request during the cycle is dropped
    w = $random(seed);
    rf_put(9'h040, w);
    rf_wr = 1'b1;
    step(1);
    rf_wdata = ~w;
    chk(32'(busy), 32'h1);
    step(1);
    chk(32'(act_oe), 32'h1);
    rf_wr = 1'b0;
    wait_idle();
    step(2);
    chk(rf_rdata, w);
    chk(32'(act_oe), 32'h0);
    rd_seq(11'h100, 4);
    // Busy mode follows the command; no supply releases the pin
    mode = eeprom_i2c_pkg::MODE_BUSY;
    cmd = 1'b1;
    step(3);
    chk(32'(act_oe), 32'h1);
    vcc_ok = 1'b0;
    step(5);
    chk(32'(act_oe), 32'h0);
    vcc_ok = 1'b1;
    cmd = 1'b0;
    mode = eeprom_i2c_pkg::MODE_WIP;
    step(5);
    chk(32'(act_oe), 32'h0);
    for (int i = 0; i < 4; i++) begin
      {h_en, f_ok} = 2'(i);
      step(5);
      chk(32'(h_oe), 32'(i == 3));
    end
    // Back-to-back contactless writes stall the drain until it refuses
    rf_put(9'h1F0, $random(seed));
    rf_wr = 1'b1;
    wr_seq(11'h000, 34, 32);
    rf_wr = 1'b0;
    wait_idle();
    rd_seq(11'h000, 32);
    rd_seq(11'h7C0, 4);
    finish_test();
  end
endmodule
